/* ssqi_pkg.sv */
// Contract
// - query keyword plus setting returns its value
// - help command lists every query command
// - offset query: tap 0 all, 1-2 one
// - noise range query reports each pixel
// - response range query reports each pixel
// - line-sample query reports averaged line count
// - io configuration query reports every signal mode
// - raw dump emits coefficients without formatting
// - statistics query answers 0 off, 1 on
// - enable query: noise flag then response flag
// - model query returns model number string
// - total gain equals user plus reference gain
package ssqi_pkg;

   // ****************************************
   // geometry
   // ****************************************
   localparam int NTAP        = 2;
   localparam int TAP_W       = 1;
   localparam int NPIX        = 1024;
   localparam int PIX_W       = 10;
   localparam int COEF_W      = 16;
   localparam int MODEL_WORDS = 2;
   localparam int NUM_OPS     = 11;

   localparam logic [15:0]      NTAP_ARG   = 16'h0002;
   localparam logic [15:0]      NPIX_ARG   = 16'h0400;
   localparam logic [PIX_W-1:0] LAST_PAIR  = 10'h001;
   localparam logic [PIX_W-1:0] LAST_MODEL = 10'h001;
   localparam logic [PIX_W-1:0] LAST_HELP  = 10'h00A;
   localparam logic [PIX_W-1:0] TAP_ALL_LO = 10'h001;
   localparam logic [PIX_W-1:0] TAP_ALL_HI = 10'h002;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_CMD       = 8'h00;
   localparam logic [7:0] OFF_ARG       = 8'h04;
   localparam logic [7:0] OFF_STATUS    = 8'h08;
   localparam logic [7:0] OFF_RESP      = 8'h0C;
   localparam logic [7:0] OFF_OFFSET    = 8'h10;
   localparam logic [7:0] OFF_GAIN      = 8'h14;
   localparam logic [7:0] OFF_GAIN_REF  = 8'h18;
   localparam logic [7:0] OFF_SAMPLES   = 8'h1C;
   localparam logic [7:0] OFF_GPIO      = 8'h20;
   localparam logic [7:0] OFF_FLAGS     = 8'h24;
   localparam logic [7:0] OFF_COEF_ADDR = 8'h28;
   localparam logic [7:0] OFF_COEF_DATA = 8'h2C;
   localparam logic [7:0] OFF_TOTAL     = 8'h30;

   // field positions
   localparam int FLD_COEF_SEL = 16;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [15:0] RST_OFFSET  = 16'h0050;
   localparam logic [15:0] RST_SAMPLES = 16'h0400;
   localparam logic        RST_ELS     = 1'b1;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [7:0] {
      OP_NONE                         = 8'h00,
      OP_ANALOG_OFFSET                = 8'h01,
      OP_FIXED_PATTERN_NOISE          = 8'h02,
      OP_PHOTO_RESPONSE_NONUNIFORMITY = 8'h03,
      OP_LINE_SAMPLES                 = 8'h04,
      OP_IO_CONFIG                    = 8'h05,
      OP_RAW_DUMP                     = 8'h06,
      OP_EOL_STATS                    = 8'h07,
      OP_COEF_ENABLE                  = 8'h08,
      OP_MODEL_NUMBER                 = 8'h09,
      OP_TOTAL_GAIN                   = 8'h0A,
      OP_HELP_LISTING_CMD             = 8'h0B
   } ssqi_op_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_BUILD = 2'b10,
      ST_HOLD  = 2'b11
   } ssqi_fsm_t;

   typedef struct packed {
      logic [NTAP-1:0][15:0] offset;
      logic [NTAP-1:0][15:0] gain;
      logic [NTAP-1:0][15:0] gain_ref;
      logic [15:0]           samples;
      logic [31:0]           gpio;
      logic                  eol_stats;
      logic                  fixed_pattern_noise_en;
      logic                  photo_response_nonuniformity_en;
   } ssqi_cfg_t;

   typedef struct packed {
      logic             bad;
      logic [PIX_W-1:0] first;
      logic [PIX_W-1:0] last;
   } ssqi_plan_t;

   typedef struct packed {
      ssqi_fsm_t        fsm;
      ssqi_op_t         op;
      logic [PIX_W-1:0] idx;
      logic [PIX_W-1:0] last;
      logic             pend;
      logic             pwr;
      logic [7:0]       paddr;
      logic [31:0]      hrdata;
      logic             hready;
      logic             hresp;
      ssqi_cfg_t        cfg;
      logic [15:0]      arg_start;
      logic [15:0]      arg_end;
      logic [31:0]      resp;
      logic             rvalid;
      logic             rlast;
      logic             err;
      logic             done;
      logic             coef_sel;
      logic [PIX_W-1:0] coef_addr;
   } ssqi_regs_t;

   localparam ssqi_regs_t RST_REGS = '{
      fsm: ST_IDLE,
      op: OP_NONE,
      hready: 1'b1,
      cfg: '{offset: {RST_OFFSET, RST_OFFSET}, samples: RST_SAMPLES, eol_stats: RST_ELS, default: '0},
      default: '0
   };

endpackage : ssqi_pkg

/* ssqi_gain_sum.sv */
`timescale 1ns/1ps
// ****************************************
// per-tap total analog gain
// ****************************************
module ssqi_gain_sum
   import ssqi_pkg::*;
(
   // settings
   input  wire logic [NTAP-1:0][15:0] gain,
   input  wire logic [NTAP-1:0][15:0] gain_ref,
   // result
   output logic      [NTAP-1:0][15:0] total
);

   // one adder per tap, gain in signed tenths of a dB
   for (genvar t = 0; t < NTAP; t++) begin : g_tap
      assign total[t] = gain[t] + gain_ref[t];
   end

endmodule : ssqi_gain_sum

/* ssqi_coef_store.sv */
`timescale 1ns/1ps
// ****************************************
// pixel coefficient memories
// ****************************************
module ssqi_coef_store
   import ssqi_pkg::*;
(
   // clock
   input  wire logic              hclk,
   input  wire logic              ce,
   // write port
   input  wire logic              wr_en,
   input  wire logic              wr_sel,
   input  wire logic [PIX_W-1:0]  wr_addr,
   input  wire logic [COEF_W-1:0] wr_data,
   // read port, one cycle latency
   input  wire logic [PIX_W-1:0]  rd_addr,
   output logic      [COEF_W-1:0] rd_data [2]
);

   logic [COEF_W-1:0] mem [2][NPIX];

   // bank 0 noise offsets, bank 1 response gains; no reset, ram style
   for (genvar b = 0; b < 2; b++) begin : g_bank
      always_ff @(posedge hclk) begin
         if (ce) begin
            if (wr_en && (wr_sel == 1'(b))) begin
               mem[b][wr_addr] <= wr_data;
            end
            rd_data[b] <= mem[b][rd_addr];
         end
      end
   end

endmodule : ssqi_coef_store

/* ssqi_interp.sv */
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
// ****************************************
// settings query interpreter
// ****************************************
module ssqi_interp
   import ssqi_pkg::*;
#(
   // model string words, value arbitrary
   parameter logic [MODEL_WORDS-1:0][31:0] MODEL_ID = {32'h5158_0001, 32'h4D44_4C30}
)
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp
);

   ssqi_regs_t            r;
   ssqi_regs_t            next_r;
   ssqi_plan_t            plan;
   logic                  launch;
   logic                  pop;
   logic                  coef_we;
   logic                  busy;
   logic [NTAP-1:0][15:0] total;
   logic [COEF_W-1:0]     coef_q [2];

   // ****************************************
   // helpers
   // ****************************************
   ssqi_gain_sum u_gain_sum (
      .gain     (r.cfg.gain),
      .gain_ref (r.cfg.gain_ref),
      .total    (total)
   );

   ssqi_coef_store u_coef_store (
      .hclk    (hclk),
      .ce      (ce),
      .wr_en   (coef_we),
      .wr_sel  (r.coef_sel),
      .wr_addr (r.coef_addr),
      .wr_data (hwdata[COEF_W-1:0]),
      .rd_addr (r.idx),
      .rd_data (coef_q)
   );

   assign busy      = (r.fsm != ST_IDLE);
   assign hrdata    = r.hrdata;
   assign hreadyout = r.hready;
   assign hresp     = r.hresp;

   // ****************************************
   // command check
   // ****************************************
   // decides the word range to emit, or flags the command as bad
   function automatic ssqi_plan_t plan_cmd(input ssqi_op_t op, input logic [15:0] s, input logic [15:0] e);
      ssqi_plan_t p;
      p = '{bad: 1'b0, first: '0, last: '0};
      unique case (op)
         OP_ANALOG_OFFSET, OP_TOTAL_GAIN: begin
            if (s > NTAP_ARG) begin
               p.bad = 1'b1;
            end else if (s == 16'h0000) begin
               p.first = TAP_ALL_LO;
               p.last  = TAP_ALL_HI;
            end else begin
               p.first = s[PIX_W-1:0];
               p.last  = s[PIX_W-1:0];
            end
         end
         OP_FIXED_PATTERN_NOISE, OP_PHOTO_RESPONSE_NONUNIFORMITY, OP_RAW_DUMP: begin
            if ((e < s) || (e >= NPIX_ARG)) begin
               p.bad = 1'b1;
            end else begin
               p.first = s[PIX_W-1:0];
               p.last  = e[PIX_W-1:0];
            end
         end
         OP_LINE_SAMPLES, OP_IO_CONFIG, OP_EOL_STATS: begin
            p.last = '0;
         end
         OP_COEF_ENABLE: begin
            p.last = LAST_PAIR;
         end
         OP_MODEL_NUMBER: begin
            p.last = LAST_MODEL;
         end
         OP_HELP_LISTING_CMD: begin
            p.last = LAST_HELP;
         end
         default: begin
            p.bad = 1'b1;
         end
      endcase
      return p;
   endfunction : plan_cmd

   // ****************************************
   // answer word builder
   // ****************************************
   function automatic logic [31:0] build_word(input ssqi_regs_t q, input logic [NTAP-1:0][15:0] tot,
                                              input logic [COEF_W-1:0] fq, input logic [COEF_W-1:0] pq);
      logic [31:0]      w;
      logic [PIX_W-1:0] tm;
      w  = 32'h0000_0000;
      tm = q.idx - TAP_ALL_LO;
      unique case (q.op)
         OP_ANALOG_OFFSET: begin
            w = {16'h0000, q.cfg.offset[tm[TAP_W-1:0]]};
         end
         OP_TOTAL_GAIN: begin
            w = {16'h0000, tot[tm[TAP_W-1:0]]};
         end
         OP_FIXED_PATTERN_NOISE: begin
            w = {6'h00, q.idx, fq};
         end
         OP_PHOTO_RESPONSE_NONUNIFORMITY: begin
            w = {6'h00, q.idx, pq};
         end
         OP_RAW_DUMP: begin
            w = {pq, fq};
         end
         OP_LINE_SAMPLES: begin
            w = {16'h0000, q.cfg.samples};
         end
         OP_IO_CONFIG: begin
            w = q.cfg.gpio;
         end
         OP_EOL_STATS: begin
            w = {31'h0000_0000, q.cfg.eol_stats};
         end
         OP_COEF_ENABLE: begin
            w = {31'h0000_0000, (q.idx == '0) ? q.cfg.fixed_pattern_noise_en
                                               : q.cfg.photo_response_nonuniformity_en};
         end
         OP_MODEL_NUMBER: begin
            w = MODEL_ID[q.idx[0]];
         end
         // query codes run contiguously from one
         OP_HELP_LISTING_CMD: begin
            w = {22'h00_0000, q.idx + TAP_ALL_LO};
         end
         default: begin
            w = 32'h0000_0000;
         end
      endcase
      return w;
   endfunction : build_word

   // ****************************************
   // next state
   // ****************************************
   // bus slave with one wait state, then the emit sequencer
   always_comb begin
      next_r  = r;
      launch  = 1'b0;
      pop     = 1'b0;
      coef_we = 1'b0;
      plan    = plan_cmd(ssqi_op_t'(hwdata[7:0]), r.arg_start, r.arg_end);
      // data phase: hwdata stands now, hrdata is loaded for the next edge
      if (r.pend) begin
         next_r.pend   = 1'b0;
         next_r.hready = 1'b1;
         if (r.pwr) begin
            case (r.paddr)
               OFF_CMD:       launch = !busy;
               OFF_ARG:       {next_r.arg_end, next_r.arg_start} = hwdata;
               OFF_OFFSET:    next_r.cfg.offset = hwdata;
               OFF_GAIN:      next_r.cfg.gain = hwdata;
               OFF_GAIN_REF:  next_r.cfg.gain_ref = hwdata;
               OFF_SAMPLES:   next_r.cfg.samples = hwdata[15:0];
               OFF_GPIO:      next_r.cfg.gpio = hwdata;
               OFF_FLAGS: begin
                  next_r.cfg.eol_stats                       = hwdata[0];
                  next_r.cfg.fixed_pattern_noise_en          = hwdata[1];
                  next_r.cfg.photo_response_nonuniformity_en = hwdata[2];
               end
               OFF_COEF_ADDR: begin
                  next_r.coef_addr = hwdata[PIX_W-1:0];
                  next_r.coef_sel  = hwdata[FLD_COEF_SEL];
               end
               // auto-increment so a whole line loads without re-addressing
               OFF_COEF_DATA: begin
                  coef_we          = 1'b1;
                  next_r.coef_addr = r.coef_addr + TAP_ALL_LO;
               end
               default: ;
            endcase
         end else begin
            case (r.paddr)
               OFF_CMD:       next_r.hrdata = {24'h00_0000, r.op};
               OFF_ARG:       next_r.hrdata = {r.arg_end, r.arg_start};
               OFF_STATUS:    next_r.hrdata = {27'h000_0000, r.done, r.err, r.rlast, r.rvalid, busy};
               OFF_RESP: begin
                  next_r.hrdata = r.resp;
                  pop           = r.rvalid;
               end
               OFF_OFFSET:    next_r.hrdata = r.cfg.offset;
               OFF_GAIN:      next_r.hrdata = r.cfg.gain;
               OFF_GAIN_REF:  next_r.hrdata = r.cfg.gain_ref;
               OFF_SAMPLES:   next_r.hrdata = {16'h0000, r.cfg.samples};
               OFF_GPIO:      next_r.hrdata = r.cfg.gpio;
               OFF_FLAGS:     next_r.hrdata = {29'h0000_0000, r.cfg.photo_response_nonuniformity_en,
                                               r.cfg.fixed_pattern_noise_en, r.cfg.eol_stats};
               OFF_COEF_ADDR: next_r.hrdata = {15'h0000, r.coef_sel, 6'h00, r.coef_addr};
               OFF_TOTAL:     next_r.hrdata = total;
               default:       next_r.hrdata = 32'h0000_0000;
            endcase
         end
      end else if (hsel && htrans[1] && hready) begin
         // address phase: only whole aligned words are expected
         next_r.pend   = 1'b1;
         next_r.pwr    = hwrite;
         next_r.paddr  = {haddr[7:2], 2'b00};
         next_r.hready = 1'b0;
      end

      // sequencer: one word per response read
      unique case (r.fsm)
         ST_IDLE: begin
            if (launch) begin
               next_r.done = 1'b0;
               if (plan.bad) begin
                  next_r.err  = 1'b1;
                  next_r.done = 1'b1;
               end else begin
                  next_r.err  = 1'b0;
                  next_r.op   = ssqi_op_t'(hwdata[7:0]);
                  next_r.idx  = plan.first;
                  next_r.last = plan.last;
                  next_r.fsm  = ST_FETCH;
               end
            end
         end
         // coefficient ram samples idx on this edge
         ST_FETCH: begin
            next_r.fsm = ST_BUILD;
         end
         ST_BUILD: begin
            next_r.resp   = build_word(r, total, coef_q[0], coef_q[1]);
            next_r.rvalid = 1'b1;
            next_r.rlast  = (r.idx == r.last);
            next_r.fsm    = ST_HOLD;
         end
         ST_HOLD: begin
            if (pop) begin
               next_r.rvalid = 1'b0;
               if (r.idx == r.last) begin
                  next_r.fsm  = ST_IDLE;
                  next_r.done = 1'b1;
               end else begin
                  next_r.idx = r.idx + TAP_ALL_LO;
                  next_r.fsm = ST_FETCH;
               end
            end
         end
      endcase
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= RST_REGS;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic [PIX_W-1:0] a_tap;
   assign a_tap = r.idx - TAP_ALL_LO;

   sequence s_launch_ok;
      ce && launch && !plan.bad;
   endsequence

   sequence s_build(ssqi_op_t o);
      ce && (r.fsm == ST_BUILD) && (r.op == o);
   endsequence

   property p_query_answers;
      s_launch_ok ##1 ce ##1 ce |=> r.rvalid && (r.fsm == ST_HOLD);
   endproperty
   a_query_answers: assert property (p_query_answers) else $error("query gave no answer word");

   property p_help_count;
      s_launch_ok and (hwdata[7:0] == 8'h0B) |=> (r.idx == 10'h000) && (r.last == LAST_HELP);
   endproperty
   a_help_count: assert property (p_help_count) else $error("help listing length wrong");

   property p_offset_all;
      s_launch_ok and (hwdata[7:0] == 8'h01) and (r.arg_start == 16'h0000)
         |=> (r.idx == TAP_ALL_LO) && (r.last == TAP_ALL_HI);
   endproperty
   a_offset_all: assert property (p_offset_all) else $error("tap zero did not select all taps");

   property p_noise_range;
      s_build(OP_FIXED_PATTERN_NOISE) |=> (r.resp[25:16] == $past(r.idx)) && (r.resp[15:0] == $past(coef_q[0]));
   endproperty
   a_noise_range: assert property (p_noise_range) else $error("noise coefficient word wrong");

   property p_resp_range;
      s_build(OP_PHOTO_RESPONSE_NONUNIFORMITY) |=> r.resp[15:0] == $past(coef_q[1]);
   endproperty
   a_resp_range: assert property (p_resp_range) else $error("response coefficient word wrong");

   property p_samples;
      s_build(OP_LINE_SAMPLES) |=> r.resp == {16'h0000, $past(r.cfg.samples)};
   endproperty
   a_samples: assert property (p_samples) else $error("line sample count wrong");

   property p_io_config;
      s_build(OP_IO_CONFIG) |=> r.resp == $past(r.cfg.gpio);
   endproperty
   a_io_config: assert property (p_io_config) else $error("io configuration word wrong");

   property p_raw_dump;
      s_build(OP_RAW_DUMP) |=> r.resp == {$past(coef_q[1]), $past(coef_q[0])};
   endproperty
   a_raw_dump: assert property (p_raw_dump) else $error("raw dump word wrong");

   property p_eol_stats;
      s_build(OP_EOL_STATS) |=> r.resp == {31'h0000_0000, $past(r.cfg.eol_stats)};
   endproperty
   a_eol_stats: assert property (p_eol_stats) else $error("statistics flag wrong");

   property p_coef_enable;
      s_build(OP_COEF_ENABLE) and (r.idx == 10'h000) |=> r.resp[0] == $past(r.cfg.fixed_pattern_noise_en);
   endproperty
   a_coef_enable: assert property (p_coef_enable) else $error("noise enable not reported first");

   property p_model;
      s_build(OP_MODEL_NUMBER) |=> r.resp == MODEL_ID[$past(r.idx[0])];
   endproperty
   a_model: assert property (p_model) else $error("model word wrong");

   property p_total_gain;
      s_build(OP_TOTAL_GAIN) |=>
         r.resp[15:0] == 16'($past(r.cfg.gain[a_tap[0]]) + $past(r.cfg.gain_ref[a_tap[0]]));
   endproperty
   a_total_gain: assert property (p_total_gain) else $error("total gain not the sum");

   property p_bad_refused;
      ce && launch && plan.bad |=> r.err && r.done && (r.fsm == ST_IDLE) && (r.cfg == $past(r.cfg));
   endproperty
   a_bad_refused: assert property (p_bad_refused) else $error("bad query not refused cleanly");

endmodule : ssqi_interp

/* ssqi_host.sv */
`timescale 1ns/1ps
// ****************************************
// host bus master model
// ****************************************
module ssqi_host (
   // bus clock and answer
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // bus request
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   // hang flag
   output logic             tmo
);
   initial begin
      hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
      hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000; tmo = 1'b0;
   end

   // bounded wait for hready sampled high at an edge
   // hready only moves on rising edges, so the falling edge shows what the next rising edge samples;
   // reading it right after the rising edge would race the slave's own update
   task automatic wait_rdy;
      int   n;
      logic rdy;
      n   = 0;
      rdy = 1'b0;
      do begin
         @(negedge hclk);
         rdy = hready;
         @(posedge hclk);
         n++;
      end while (rdy !== 1'b1 && n < 100);
      if (rdy !== 1'b1) tmo = 1'b1;
   endtask : wait_rdy

   // one single-word transfer, address phase then data phase with the write data
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {24'h0000_00, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      // released data lines show a changed pattern, not the stale value
      hwdata <= ~wd;
   endtask : xfer
endmodule : ssqi_host

/* ssqi_interp_test.sv */
`timescale 1ns/1ps
module ssqi_interp_test
   import ssqi_pkg::*;
;
   // ****************************************
   // signals
   // ****************************************
   localparam logic [1:0][31:0] MID = {32'h0BAD_0002, 32'h0BAD_0001}; // arbitrary model words
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, tmo;
   logic [31:0] haddr, hwdata, hrdata, t;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          mismatches, n_tests;

   // bus master and design
   ssqi_host host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .tmo(tmo));
   ssqi_interp #(.MODEL_ID(MID)) dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

   // 25 ns clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
      if (tmo === 1'b1) begin
         mismatches++;
         results();
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, t);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      host_u.xfer(1'b0, a, 32'h0000_0000, t);
      chk(nm, e, t);
   endtask : rd

   task automatic query(input logic [7:0] op, input logic [31:0] arg);
      wr(OFF_ARG, arg);
      wr(OFF_CMD, {24'h0000_00, op});
   endtask : query

   // bounded poll for a ready answer word, then pop and compare it
   task automatic pop(input logic [31:0] e);
      int n;
      for (n = 0; n < 60; n++) begin
         host_u.xfer(1'b0, OFF_STATUS, 32'h0000_0000, t);
         if (t[1] === 1'b1) break;
      end
      if (n == 60) begin
         mismatches++;
         results();
      end
      rd("resp", OFF_RESP, e);
   endtask : pop

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      mismatches = 0;
      n_tests = 0;
      hresetn = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd("offset", OFF_OFFSET, 32'h0050_0050);
      rd("samples", OFF_SAMPLES, 32'h0000_0400);
      rd("flags", OFF_FLAGS, 32'h0000_0001);
      rd("unmapped", 8'h40, 32'h0000_0000);
      chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
      $display("test reset done");
      query(8'h01, 32'h0000_0000); pop(32'h0000_0050); pop(32'h0000_0050);
      wr(OFF_OFFSET, 32'h0030_0011);
      query(8'h01, 32'h0000_0002); pop(32'h0000_0030);
      rd("status", OFF_STATUS, 32'h0000_0014);
      wr(OFF_GAIN, 32'h0002_0001);
      wr(OFF_GAIN_REF, 32'h0010_0020);
      rd("total", OFF_TOTAL, 32'h0012_0021);
      query(8'h0A, 32'h0000_0000); pop(32'h0000_0021); pop(32'h0000_0012);
      query(8'h04, 32'h0000_0000); pop(32'h0000_0400);
      wr(OFF_GPIO, 32'h1234_5678);
      query(8'h05, 32'h0000_0000); pop(32'h1234_5678);
      query(8'h07, 32'h0000_0000); pop(32'h0000_0001);
      wr(OFF_FLAGS, 32'h0000_0002);
      query(8'h07, 32'h0000_0000); pop(32'h0000_0000);
      query(8'h08, 32'h0000_0000); pop(32'h0000_0001); pop(32'h0000_0000);
      query(8'h09, 32'h0000_0000); pop(MID[0]); pop(MID[1]);
      $display("test settings done");
      // coefficient banks loaded at pixels 1022 and 1023
      wr(OFF_COEF_ADDR, 32'h0000_03FE); wr(OFF_COEF_DATA, 32'h0000_AAA1); wr(OFF_COEF_DATA, 32'h0000_AAA2);
      wr(OFF_COEF_ADDR, 32'h0001_03FE); wr(OFF_COEF_DATA, 32'h0000_BBB1); wr(OFF_COEF_DATA, 32'h0000_BBB2);
      query(8'h02, 32'h03FF_03FE); pop(32'h03FE_AAA1); pop(32'h03FF_AAA2);
      query(8'h03, 32'h03FF_03FE); pop(32'h03FE_BBB1); pop(32'h03FF_BBB2);
      query(8'h06, 32'h03FF_03FF); pop(32'hBBB2_AAA2);
      query(8'h0B, 32'h0000_0000);
      for (int i = 1; i <= 11; i++) pop(i);
      $display("test coefficients and help done");
      query(8'h0C, 32'h0000_0000); rd("status", OFF_STATUS, 32'h0000_001C);
      query(8'h01, 32'h0000_0003); rd("status", OFF_STATUS, 32'h0000_001C);
      query(8'h02, 32'h0004_0005); rd("status", OFF_STATUS, 32'h0000_001C);
      query(8'h03, 32'h0400_0000); rd("status", OFF_STATUS, 32'h0000_001C);
      rd("offset", OFF_OFFSET, 32'h0030_0011);
      $display("test refusals done");
      results();
   end
endmodule : ssqi_interp_test
